//--- rtl/frs_sequencer.sv
// flash rewrite sequencer: interrupt handling, erase suspend, abort
//
// The placing of the registers and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/100ps
module frs_sequencer
  import frs_pkg::*;
(
  input  wire logic                 core_clk_i,
  input  wire logic                 reset_i,
  input  wire logic [3:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic [31:0]               avs_readdata,
  output logic                      avs_waitrequest,
  input  wire logic                 op_start_i,
  input  wire logic                 op_is_erase_i,
  input  wire logic                 op_rom_i,
  input  wire logic                 op_suspendable_i,
  input  wire logic [FRS_BLK_W-1:0] op_block_i,
  input  wire logic                 op_done_i,
  input  wire logic                 irq_req_i,
  input  wire logic                 irq_ack_i,
  input  wire logic                 nmi_event_i,
  input  wire logic                 acc_req_i,
  input  wire logic [FRS_BLK_W-1:0] acc_block_i,
  output logic                      acc_grant_o,
  output logic                      irq_allow_o,
  output logic                      flash_run_o,
  output logic                      flash_reset_o,
  output logic                      nmi_go_o,
  output logic                      cpu_rewrite_en_o,
  output logic                      lowcur_read_en_o
);
  frs_state_e           state;
  frs_state_e           next_state;
  frs_op_e              op;
  frs_op_e              next_op;
  logic                 op_rom;
  logic                 next_op_rom;
  logic                 op_susp;
  logic                 next_op_susp;
  logic [FRS_BLK_W-1:0] blk;
  logic [FRS_BLK_W-1:0] next_blk;
  logic [FRS_CW-1:0]    cnt;
  logic [FRS_CW-1:0]    next_cnt;
  logic                 susp_req;
  logic                 next_susp_req;
  logic                 aborted;
  logic                 next_aborted;
  logic                 nmi_pend;
  logic                 next_nmi_pend;
  logic                 rom_exec;
  logic                 next_rom_exec;
  logic                 ack_phase;
  logic                 next_ack_phase;
  logic [31:0]          next_rdata;
  logic                 next_grant;
  logic                 next_irq_allow;
  logic                 next_nmi_go;

  logic wr0;
  logic wr1;
  logic wr2;
  logic rd_cyc;
  logic cpu_rw;
  logic lockbit_dis;
  logic stat_clr;
  logic susp_en;
  logic irq_susp_en;
  logic lowcur;
  logic [3:0] prot;
  logic rom_erase_susp;
  logic next_rom_susp;

  // single wait cycle: a write is taken while ack_phase is high, a read while ack_phase is low
  assign wr0 = ack_phase & avs_write & avs_byteenable[0] &
               (avs_address == FRS_OFS_CTRL0);
  assign wr1 = ack_phase & avs_write & avs_byteenable[0] &
               (avs_address == FRS_OFS_CTRL1);
  assign wr2 = ack_phase & avs_write & avs_byteenable[0] &
               (avs_address == FRS_OFS_CTRL2);
  assign rd_cyc = avs_read & ~ack_phase;

  frs_prot_bit #(.RST_VAL(1'b0), .GUARD_VAL(1'b1)) u_cpu_rw (
    .core_clk_i (core_clk_i), .reset_i (reset_i), .wr_i (wr0),
    .wdata_i (avs_writedata[FRS_B_CPU_REWRITE]), .value_o (cpu_rw));
  frs_prot_bit #(.RST_VAL(1'b0), .GUARD_VAL(1'b1)) u_lock (
    .core_clk_i (core_clk_i), .reset_i (reset_i), .wr_i (wr0),
    .wdata_i (avs_writedata[FRS_B_LOCKBIT_DIS]), .value_o (lockbit_dis));
  frs_prot_bit #(.RST_VAL(1'b0), .GUARD_VAL(1'b1)) u_sclr (
    .core_clk_i (core_clk_i), .reset_i (reset_i), .wr_i (wr1),
    .wdata_i (avs_writedata[FRS_B_STATUS_CLR]), .value_o (stat_clr));
  frs_prot_bit #(.RST_VAL(1'b0), .GUARD_VAL(1'b1)) u_sen (
    .core_clk_i (core_clk_i), .reset_i (reset_i), .wr_i (wr2),
    .wdata_i (avs_writedata[FRS_B_SUSP_EN]), .value_o (susp_en));
  frs_prot_bit #(.RST_VAL(1'b0), .GUARD_VAL(1'b1)) u_isen (
    .core_clk_i (core_clk_i), .reset_i (reset_i), .wr_i (wr2),
    .wdata_i (avs_writedata[FRS_B_IRQ_SUSP_EN]), .value_o (irq_susp_en));
  frs_prot_bit #(.RST_VAL(1'b0), .GUARD_VAL(1'b1)) u_lc (
    .core_clk_i (core_clk_i), .reset_i (reset_i), .wr_i (wr2),
    .wdata_i (avs_writedata[FRS_B_LOWCUR_EN]), .value_o (lowcur));

  // protection bits guard the clearing direction
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_prot
      frs_prot_bit #(.RST_VAL(1'b1), .GUARD_VAL(1'b0)) u_p (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .wr_i       (wr1),
        .wdata_i    (avs_writedata[FRS_B_PROT_LO + gi]),
        .value_o    (prot[gi])
      );
    end
  endgenerate

  // suspendable erase of program rom in rom-exec mode
  assign rom_erase_susp = rom_exec & op_rom & op_susp & susp_en &
                          irq_susp_en & (op == FRS_OP_ERASE);
  assign next_rom_susp = next_rom_exec & next_op_rom & next_op_susp &
    susp_en & irq_susp_en & (next_op == FRS_OP_ERASE);

  always_comb begin
    next_state     = state;
    next_op        = op;
    next_op_rom    = op_rom;
    next_op_susp   = op_susp;
    next_blk       = blk;
    next_cnt       = cnt;
    next_susp_req  = susp_req;
    next_aborted   = aborted;
    next_nmi_pend  = nmi_pend;
    next_rom_exec  = rom_exec;
    next_ack_phase = 1'b0;
    next_rdata     = 32'h0000_0000;
    next_nmi_go    = 1'b0;
    if ((avs_read | avs_write) & ~ack_phase) begin
      next_ack_phase = 1'b1;
    end
    if (rd_cyc) begin
      case (avs_address)
        FRS_OFS_CTRL0: begin
          next_rdata[FRS_B_CPU_REWRITE] = cpu_rw;
          next_rdata[FRS_B_LOCKBIT_DIS] = lockbit_dis;
          next_rdata[FRS_B_ROM_EXEC]    = rom_exec;
        end
        FRS_OFS_CTRL1: begin
          next_rdata[FRS_B_STATUS_CLR] = stat_clr;
          next_rdata[FRS_B_PROT_HI:FRS_B_PROT_LO] = prot;
        end
        FRS_OFS_CTRL2: begin
          next_rdata[FRS_B_SUSP_EN]     = susp_en;
          next_rdata[FRS_B_SUSP_REQ]    = susp_req;
          next_rdata[FRS_B_IRQ_SUSP_EN] = irq_susp_en;
          next_rdata[FRS_B_LOWCUR_EN]   = lowcur;
        end
        FRS_OFS_STATUS: begin
          next_rdata[FRS_B_READY]     = (state == FRS_ST_IDLE);
          next_rdata[FRS_B_SUSP_FLAG] =
            (state == FRS_ST_SUSPENDED);
          next_rdata[FRS_B_ABORTED]   = aborted;
        end
        default: next_rdata = 32'h0000_0000;
      endcase
    end
    if (wr0) begin
      next_rom_exec = avs_writedata[FRS_B_ROM_EXEC];
    end
    if (wr2) begin
      next_susp_req = avs_writedata[FRS_B_SUSP_REQ];
    end
    if (wr1 & avs_writedata[FRS_B_STATUS_CLR] & stat_clr) begin
      next_aborted = 1'b0;
    end
    case (state)
      FRS_ST_IDLE: begin
        if (nmi_pend) begin
          next_nmi_go   = 1'b1;
          next_nmi_pend = 1'b0;
        end
        if (op_start_i & cpu_rw) begin
          next_state   = FRS_ST_BUSY;
          next_op      = op_is_erase_i ? FRS_OP_ERASE : FRS_OP_PROG;
          next_op_rom  = op_rom_i;
          next_op_susp = op_suspendable_i;
          next_blk     = op_block_i;
          next_susp_req = 1'b0;
        end
      end
      FRS_ST_BUSY, FRS_ST_SUSP_WAIT: begin
        if (irq_ack_i & ~op_rom & op_susp & susp_en & irq_susp_en &
            (op == FRS_OP_ERASE)) begin
          next_susp_req = 1'b1;
        end
        if (irq_req_i & rom_erase_susp) begin
          next_susp_req = 1'b1;
        end
        if (state == FRS_ST_BUSY) begin
          if (op_done_i) begin
            next_state = FRS_ST_IDLE;
            next_op    = FRS_OP_NONE;
          end else if (next_susp_req & susp_en & op_susp &
                       (op == FRS_OP_ERASE)) begin
            next_state = FRS_ST_SUSP_WAIT;
            next_cnt   = FRS_SUSP_CNT;
          end
        end else if (cnt <= FRS_CW'(1)) begin
          next_state = FRS_ST_SUSPENDED;
        end else begin
          next_cnt = cnt - FRS_CW'(1);
        end
      end
      FRS_ST_SUSPENDED: begin
        if (~susp_req) begin
          next_state = FRS_ST_BUSY;
        end
      end
      FRS_ST_RESTART: begin
        if (cnt <= FRS_CW'(1)) begin
          next_state = FRS_ST_IDLE;
        end else begin
          next_cnt = cnt - FRS_CW'(1);
        end
      end
      default: next_state = FRS_ST_IDLE;
    endcase
    // nmi-class event aborts a program rom operation at once
    if (nmi_event_i) begin
      if (op_rom & (state == FRS_ST_BUSY || state == FRS_ST_SUSP_WAIT ||
                    state == FRS_ST_SUSPENDED)) begin
        next_state    = FRS_ST_RESTART;
        next_cnt      = FRS_RST_CNT;
        next_op       = FRS_OP_NONE;
        next_susp_req = 1'b0;
        next_aborted  = 1'b1;
        next_nmi_pend = 1'b1;
      end else if (state == FRS_ST_RESTART) begin
        next_nmi_pend = 1'b1;
      end else begin
        next_nmi_go = 1'b1;
      end
    end
  end

  // grant and interrupt gating
  always_comb begin
    next_grant = acc_req_i & ~(state == FRS_ST_RESTART);
    if (state == FRS_ST_BUSY || state == FRS_ST_SUSP_WAIT) begin
      next_grant = 1'b0;
    end else if (state == FRS_ST_SUSPENDED) begin
      next_grant = acc_req_i & (acc_block_i != blk);
    end
    next_irq_allow = 1'b1;
    if (next_state == FRS_ST_RESTART) begin
      next_irq_allow = 1'b0;
    end else if ((next_state == FRS_ST_BUSY) & next_rom_exec &
                 next_op_rom & ~next_rom_susp) begin
      next_irq_allow = 1'b0;
    end else if ((next_state == FRS_ST_BUSY ||
                  next_state == FRS_ST_SUSP_WAIT) & next_rom_susp) begin
      next_irq_allow = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state            <= FRS_ST_IDLE;
      op               <= FRS_OP_NONE;
      op_rom           <= 1'b0;
      op_susp          <= 1'b0;
      blk              <= '0;
      cnt              <= '0;
      susp_req         <= 1'b0;
      aborted          <= 1'b0;
      nmi_pend         <= 1'b0;
      rom_exec         <= 1'b0;
      ack_phase        <= 1'b0;
      avs_readdata     <= 32'h0000_0000;
      avs_waitrequest  <= 1'b1;
      acc_grant_o      <= 1'b0;
      irq_allow_o      <= 1'b1;
      flash_run_o      <= 1'b0;
      flash_reset_o    <= 1'b0;
      nmi_go_o         <= 1'b0;
      cpu_rewrite_en_o <= 1'b0;
      lowcur_read_en_o <= 1'b0;
    end else begin
      state            <= next_state;
      op               <= next_op;
      op_rom           <= next_op_rom;
      op_susp          <= next_op_susp;
      blk              <= next_blk;
      cnt              <= next_cnt;
      susp_req         <= next_susp_req;
      aborted          <= next_aborted;
      nmi_pend         <= next_nmi_pend;
      rom_exec         <= next_rom_exec;
      ack_phase        <= next_ack_phase;
      avs_readdata     <= next_rdata;
      avs_waitrequest  <= ~next_ack_phase;
      acc_grant_o      <= next_grant;
      irq_allow_o      <= next_irq_allow;
      flash_run_o      <= (next_state == FRS_ST_BUSY) ||
                          (next_state == FRS_ST_SUSP_WAIT);
      flash_reset_o    <= (next_state == FRS_ST_RESTART);
      nmi_go_o         <= next_nmi_go;
      cpu_rewrite_en_o <= cpu_rw;
      lowcur_read_en_o <= lowcur;
    end
  end
endmodule : frs_sequencer

//--- inc/frs_pkg.sv
// package for the flash rewrite interrupt and suspend sequencer
package frs_pkg;
  // register word offsets (byte addresses, one word each)
  localparam logic [3:0] FRS_OFS_CTRL0  = 4'h0;
  localparam logic [3:0] FRS_OFS_CTRL1  = 4'h4;
  localparam logic [3:0] FRS_OFS_CTRL2  = 4'h8;
  localparam logic [3:0] FRS_OFS_STATUS = 4'hC;
  // flash_ctrl0 fields
  localparam int FRS_B_CPU_REWRITE = 1;
  localparam int FRS_B_LOCKBIT_DIS = 2;
  localparam int FRS_B_ROM_EXEC    = 3;
  // flash_ctrl1 fields
  localparam int FRS_B_STATUS_CLR  = 3;
  localparam int FRS_B_PROT_LO     = 4;
  localparam int FRS_B_PROT_HI     = 7;
  // flash_ctrl2 fields
  localparam int FRS_B_SUSP_EN     = 0;
  localparam int FRS_B_SUSP_REQ    = 1;
  localparam int FRS_B_IRQ_SUSP_EN = 2;
  localparam int FRS_B_LOWCUR_EN   = 7;
  // flash_status_reg fields
  localparam int FRS_B_ABORTED     = 4;
  localparam int FRS_B_SUSP_FLAG   = 6;
  localparam int FRS_B_READY       = 7;
  // reset values
  localparam logic [7:0] FRS_CTRL0_RST = 8'h00;
  localparam logic [7:0] FRS_CTRL1_RST = 8'hF0;
  localparam logic [7:0] FRS_CTRL2_RST = 8'h00;
  // timing
  localparam int CLK_HZ             = 10_000_000;
  localparam int SUSP_LATENCY_US    = 30;
  localparam int SUSP_LATENCY_CYC   =
    (SUSP_LATENCY_US * (CLK_HZ / 1_000_000) > 0) ?
    SUSP_LATENCY_US * (CLK_HZ / 1_000_000) : 1;
  localparam int RESTART_US         = 20;
  localparam int RESTART_CYC        =
    (RESTART_US * (CLK_HZ / 1_000_000) > 0) ?
    RESTART_US * (CLK_HZ / 1_000_000) : 1;
  localparam int FRS_CW             = 12;
  localparam logic [FRS_CW-1:0] FRS_SUSP_CNT =
    FRS_CW'(SUSP_LATENCY_CYC);
  localparam logic [FRS_CW-1:0] FRS_RST_CNT  = FRS_CW'(RESTART_CYC);
  localparam int FRS_BLK_W          = 4;

  typedef enum logic [1:0] {
    FRS_OP_NONE,
    FRS_OP_ERASE,
    FRS_OP_PROG
  } frs_op_e;

  typedef enum logic [2:0] {
    FRS_ST_IDLE,
    FRS_ST_BUSY,
    FRS_ST_SUSP_WAIT,
    FRS_ST_SUSPENDED,
    FRS_ST_RESTART
  } frs_state_e;
endpackage : frs_pkg

//--- rtl/frs_prot_bit.sv
// one protected control bit with its unlock write sequence
`timescale 1ns/100ps
module frs_prot_bit
  import frs_pkg::*;
#(
  parameter logic RST_VAL   = 1'b0,
  parameter logic GUARD_VAL = 1'b1
) (
  input  wire logic core_clk_i,
  input  wire logic reset_i,
  input  wire logic wr_i,
  input  wire logic wdata_i,
  output logic      value_o
);
  logic armed;
  logic next_armed;
  logic next_value;

  always_comb begin
    next_armed = armed;
    next_value = value_o;
    if (wr_i) begin
      // guarded direction needs the opposite value written just before
      if (wdata_i == GUARD_VAL) begin
        if (armed) begin
          next_value = GUARD_VAL;
        end
        next_armed = 1'b0;
      end else begin
        next_value = ~GUARD_VAL;
        next_armed = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      armed   <= 1'b0;
      value_o <= RST_VAL;
    end else begin
      armed   <= next_armed;
      value_o <= next_value;
    end
  end
endmodule : frs_prot_bit

//--- test/frs_sequencer_assertions.sv
// concurrent checks on the sequencer top ports
`timescale 1ns/100ps
module frs_sequencer_assertions
  import frs_pkg::*;
(
  input wire logic       core_clk_i,
  input wire logic       reset_i,
  input wire logic [3:0] avs_address,
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic       avs_waitrequest,
  input wire logic       acc_req_i,
  input wire logic       acc_grant_o,
  input wire logic       irq_allow_o,
  input wire logic       flash_run_o,
  input wire logic       flash_reset_o,
  input wire logic       nmi_event_i,
  input wire logic       nmi_go_o,
  input wire logic       cpu_rewrite_en_o,
  input wire logic       lowcur_read_en_o
);
  logic [11:0] rst_len;
  // length of the current flash reset period
  always_ff @(posedge core_clk_i) begin
    if (reset_i || !flash_reset_o) rst_len <= 12'h000;
    else rst_len <= rst_len + 12'h001;
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  a_wait_one_cycle: assert property ((avs_read || avs_write)
    && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  a_wait_low_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_grant_cause: assert property (acc_grant_o |-> $past(acc_req_i))
    else $error("grant without request");
  a_irq_held: assert property (!irq_allow_o |-> flash_run_o || flash_reset_o)
    else $error("irq held while flash idle");
  a_abort_cause: assert property ($rose(flash_reset_o) |->
    $past(nmi_event_i) || $past(nmi_event_i, 2))
    else $error("flash reset without event");
  a_restart_len: assert property ($fell(flash_reset_o) |->
    rst_len inside {[FRS_RST_CNT - 1 : FRS_RST_CNT + 1]})
    else $error("restart period wrong");
  a_go_when_idle: assert property (nmi_go_o |-> !flash_reset_o
    && !flash_run_o ##1 !nmi_go_o)
    else $error("handling start wrong");
  a_rewrite_by_bus: assert property ($rose(cpu_rewrite_en_o) |->
    $past(avs_write && !avs_waitrequest && avs_address == FRS_OFS_CTRL0, 2))
    else $error("rewrite enable set without write");
  a_lowcur_by_bus: assert property ($rose(lowcur_read_en_o) |->
    $past(avs_write && !avs_waitrequest && avs_address == FRS_OFS_CTRL2, 2))
    else $error("low current enable set without write");
endmodule : frs_sequencer_assertions

//--- test/frs_cpu_model.sv
// cpu core and interrupt controller model
`timescale 1ns/100ps
module frs_cpu_model #(
  parameter int ACK_DLY = 3
) (
  input  wire logic core_clk_i,
  input  wire logic reset_i,
  input  wire logic raise_i,
  input  wire logic allow_i,
  output logic      irq_req_o,
  output logic      irq_ack_o
);
  logic [3:0] cnt;
  always_ff @(posedge core_clk_i) begin
    irq_ack_o <= 1'b0;
    if (reset_i) begin
      irq_req_o <= 1'b0;
      cnt <= 4'h0;
    end else if (raise_i) begin
      irq_req_o <= 1'b1;
    end else if (irq_req_o && allow_i) begin
      cnt <= cnt + 4'h1;
      if (cnt == 4'(ACK_DLY)) begin
        irq_ack_o <= 1'b1;
        irq_req_o <= 1'b0;
        cnt <= 4'h0;
      end
    end
  end
endmodule : frs_cpu_model

//--- test/frs_sequencer_test.sv
// self-checking bench for the rewrite sequencer
`timescale 1ns/100ps
module frs_sequencer_test
  import frs_pkg::*;
;
  logic core_clk_i, reset_i, avs_read, avs_write, op_start_i, op_done_i;
  logic op_is_erase_i, op_rom_i, op_suspendable_i, nmi_event_i, acc_req_i;
  logic irq_raise, avs_waitrequest, irq_req_i, irq_ack_i, acc_grant_o;
  logic irq_allow_o, flash_run_o, flash_reset_o, nmi_go_o;
  logic cpu_rewrite_en_o, lowcur_read_en_o;
  logic [3:0]  avs_address, op_block_i, acc_block_i;
  logic [31:0] avs_writedata, avs_readdata, q;
  int          errors, samples_checked, cycles;

  frs_sequencer frs_sequencer_inst (.core_clk_i, .reset_i, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hF),
    .avs_readdata, .avs_waitrequest, .op_start_i, .op_is_erase_i, .op_rom_i,
    .op_suspendable_i, .op_block_i, .op_done_i, .irq_req_i, .irq_ack_i,
    .nmi_event_i, .acc_req_i, .acc_block_i, .acc_grant_o, .irq_allow_o,
    .flash_run_o, .flash_reset_o, .nmi_go_o, .cpu_rewrite_en_o,
    .lowcur_read_en_o);
  frs_cpu_model frs_cpu_model_inst (.core_clk_i, .reset_i,
    .raise_i(irq_raise), .allow_i(irq_allow_o), .irq_req_o(irq_req_i),
    .irq_ack_o(irq_ack_i));

  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic chb(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask : chb
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    do @(posedge core_clk_i); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(q, {24'h000000, e});
  endtask : rdc
  task automatic st(input logic er, rom, sus, input logic [3:0] b);
    @(posedge core_clk_i);
    {op_is_erase_i, op_rom_i, op_suspendable_i, op_block_i} <= {er, rom, sus, b};
    op_start_i <= 1'b1;
    @(posedge core_clk_i);
    op_start_i <= 1'b0;
  endtask : st
  task automatic pulse_done();
    @(posedge core_clk_i);
    op_done_i <= 1'b1;
    @(posedge core_clk_i);
    op_done_i <= 1'b0;
  endtask : pulse_done
  task automatic raise_wait_ack();
    int n;
    n = 0;
    @(posedge core_clk_i);
    irq_raise <= 1'b1;
    @(posedge core_clk_i);
    irq_raise <= 1'b0;
    while (irq_ack_i !== 1'b1 && n < 2000) begin
      @(posedge core_clk_i);
      n++;
    end
    chb(irq_ack_i, 1'b1);
  endtask : raise_wait_ack
  task automatic acc(input logic [3:0] b, input logic e);
    @(posedge core_clk_i);
    acc_block_i <= b;
    acc_req_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    chb(acc_grant_o, e);
    acc_req_i <= 1'b0;
  endtask : acc

  task automatic t_regs();
    rdc(FRS_OFS_CTRL0, FRS_CTRL0_RST);
    rdc(FRS_OFS_CTRL1, FRS_CTRL1_RST);
    rdc(FRS_OFS_CTRL2, FRS_CTRL2_RST);
    bus(1'b1, FRS_OFS_STATUS, 8'h00);
    rdc(FRS_OFS_STATUS, 8'h80);
    rdc(4'h2, 8'h00);
  endtask : t_regs
  task automatic t_prot();
    bus(1'b1, FRS_OFS_CTRL0, 8'h02);
    rdc(FRS_OFS_CTRL0, 8'h00);
    bus(1'b1, FRS_OFS_CTRL0, 8'h00);
    bus(1'b1, FRS_OFS_CTRL0, 8'h02);
    rdc(FRS_OFS_CTRL0, 8'h02);
    chb(cpu_rewrite_en_o, 1'b1);
    bus(1'b1, FRS_OFS_CTRL1, 8'h00);
    rdc(FRS_OFS_CTRL1, 8'hF0);
    bus(1'b1, FRS_OFS_CTRL1, 8'hF0);
    bus(1'b1, FRS_OFS_CTRL1, 8'h00);
    rdc(FRS_OFS_CTRL1, 8'h00);
    bus(1'b1, FRS_OFS_CTRL2, 8'h00);
    bus(1'b1, FRS_OFS_CTRL2, 8'h85);
    rdc(FRS_OFS_CTRL2, 8'h85);
    chb(lowcur_read_en_o, 1'b1);
  endtask : t_prot
  task automatic t_dflash_susp();
    st(1'b1, 1'b0, 1'b1, 4'h3);
    bus(1'b0, FRS_OFS_STATUS, 8'h00);
    chb(q[7], 1'b0);
    raise_wait_ack();
    repeat (SUSP_LATENCY_CYC - 10) @(posedge core_clk_i);
    bus(1'b0, FRS_OFS_STATUS, 8'h00);
    chb(q[6], 1'b0);
    repeat (20) @(posedge core_clk_i);
    bus(1'b0, FRS_OFS_STATUS, 8'h00);
    chb(q[6], 1'b1);
    rdc(FRS_OFS_CTRL2, 8'h87);
    acc(4'h3, 1'b0);
    acc(4'h5, 1'b1);
    bus(1'b1, FRS_OFS_CTRL2, 8'h85);
    repeat (3) @(posedge core_clk_i);
    chb(flash_run_o, 1'b1);
    pulse_done();
    repeat (3) @(posedge core_clk_i);
    rdc(FRS_OFS_STATUS, 8'h80);
  endtask : t_dflash_susp
  task automatic t_dflash_prog();
    st(1'b0, 1'b0, 1'b0, 4'h2);
    raise_wait_ack();
    chb(flash_run_o, 1'b1);
    pulse_done();
  endtask : t_dflash_prog
  task automatic t_sw_susp();
    bus(1'b1, FRS_OFS_CTRL2, 8'h81);
    st(1'b1, 1'b0, 1'b1, 4'h4);
    raise_wait_ack();
    repeat (SUSP_LATENCY_CYC + 5) @(posedge core_clk_i);
    rdc(FRS_OFS_STATUS, 8'h00);
    bus(1'b1, FRS_OFS_CTRL2, 8'h83);
    repeat (SUSP_LATENCY_CYC + 5) @(posedge core_clk_i);
    rdc(FRS_OFS_STATUS, 8'h40);
    bus(1'b1, FRS_OFS_CTRL2, 8'h85);
    pulse_done();
    repeat (3) @(posedge core_clk_i);
    rdc(FRS_OFS_CTRL2, 8'h85);
  endtask : t_sw_susp
  task automatic t_rom_pending();
    bus(1'b1, FRS_OFS_CTRL0, 8'h0A);
    st(1'b0, 1'b1, 1'b0, 4'h1);
    raise_wait_ack();
  endtask : t_rom_pending
  task automatic t_rom_flow();
    fork
      t_rom_pending();
      begin
        repeat (60) @(posedge core_clk_i);
        chb(irq_req_i, 1'b1);
        pulse_done();
      end
    join
    @(posedge core_clk_i);
    chb(irq_ack_i, 1'b0);
    st(1'b1, 1'b1, 1'b1, 4'h2);
    raise_wait_ack();
    bus(1'b0, FRS_OFS_STATUS, 8'h00);
    chb(q[6], 1'b1);
    bus(1'b1, FRS_OFS_CTRL2, 8'h85);
    pulse_done();
  endtask : t_rom_flow
  task automatic t_nmi();
    int n;
    n = 0;
    st(1'b0, 1'b1, 1'b0, 4'h5);
    nmi_event_i <= 1'b1;
    @(posedge core_clk_i);
    nmi_event_i <= 1'b0;
    while (nmi_go_o !== 1'b1 && n < 1000) begin
      @(posedge core_clk_i);
      n++;
    end
    chb(n >= RESTART_CYC, 1'b1);
    bus(1'b0, FRS_OFS_STATUS, 8'h00);
    chb(q[4], 1'b1);
    st(1'b1, 1'b1, 1'b0, 4'h5);
    pulse_done();
    repeat (2) @(posedge core_clk_i);
    rdc(FRS_OFS_STATUS, 8'h90);
    bus(1'b1, FRS_OFS_CTRL2, 8'h05);
    repeat (2) @(posedge core_clk_i);
    chb(lowcur_read_en_o, 1'b0);
  endtask : t_nmi

  initial begin
    {avs_read, avs_write, op_start_i, op_done_i, nmi_event_i} = 5'h00;
    {op_is_erase_i, op_rom_i, op_suspendable_i, acc_req_i, irq_raise} = 5'h00;
    {avs_address, op_block_i, acc_block_i} = 12'h000;
    avs_writedata = 32'h00000000;
    reset_i = 1'b1;
    repeat (5) @(posedge core_clk_i);
    reset_i <= 1'b0;
    t_regs();
    t_prot();
    t_dflash_susp();
    t_dflash_prog();
    t_sw_susp();
    t_rom_flow();
    t_nmi();
    end_sim();
  end
endmodule : frs_sequencer_test

bind frs_sequencer frs_sequencer_assertions frs_sequencer_assertions_inst (
  .core_clk_i, .reset_i, .avs_address, .avs_read, .avs_write,
  .avs_waitrequest, .acc_req_i, .acc_grant_o, .irq_allow_o, .flash_run_o,
  .flash_reset_o, .nmi_event_i, .nmi_go_o, .cpu_rewrite_en_o,
  .lowcur_read_en_o);
